//--- src/fifo_status_flags_and_mailbox.sv
// Status flags, offset registers and mailboxes of a bidirectional two-port FIFO
//
// Local design decisions: the address map and the AXI4-Lite slave port.
`timescale 1ns/10ps
`include "fifo_flags_cfg.svh"

module fifo_status_flags_and_mailbox #(
  parameter int DEPTH = 1024
) (
  input  wire logic                        sys_clk,
  input  wire logic                        rst,
  input  wire fifo_flags_pkg::axi_req_type axiReq,
  output      fifo_flags_pkg::axi_rsp_type axiRsp,
  input  wire fifo_flags_pkg::port_pins_type portAPins,
  input  wire fifo_flags_pkg::port_pins_type portBPins,
  input  wire logic                        fifoOneRead,
  input  wire logic                        fifoTwoRead,
  input  wire logic [35:0]                 fifoOneOutData,
  input  wire logic [35:0]                 fifoTwoOutData,
  output      logic [35:0]                 portAData,
  output      logic                        portADataOe,
  output      logic [35:0]                 portBData,
  output      logic                        portBDataOe,
  output      logic                        portASpaceFlag,
  output      logic                        portBSpaceFlag,
  output      logic                        portAHighFillFlag,
  output      logic                        portBHighFillFlag,
  output      logic                        portALowFillFlag,
  output      logic                        portBLowFillFlag,
  output      logic                        mailOneFlag,
  output      logic                        mailTwoFlag
);
  import fifo_flags_pkg::*;

  localparam int CW = $clog2(DEPTH) + 2;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic logic [35:0] laneMask(input bus_size_type size);
    unique case (size)
      BUS_LONG: laneMask = `MASK_LONG;
      BUS_WORD: laneMask = `MASK_WORD;
      BUS_BYTE: laneMask = `MASK_BYTE;
      default:  laneMask = `MASK_LONG;
    endcase
  endfunction

  function automatic logic [31:0] applyStrb(input logic [31:0] old, input logic [31:0] wdat,
                                            input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[b*8 +: 8] = wdat[b*8 +: 8];
      end
    end
    applyStrb = res;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Port decode, index 0 is FIFO one (A writes, B reads), index 1 FIFO two

  logic                  aWriteSel;
  logic                  aReadSel;
  logic                  bWriteSel;
  logic                  bReadSel;
  logic [1:0]            wrClkEn;
  logic [1:0]            rdClkEn;
  logic [1:0]            wrTake;
  logic [1:0]            rdTake;
  logic [1:0]            mailWrite;
  logic [1:0]            mailRead;
  logic [CW-1:0]         count_q [2];
  logic [CW-1:0]         countW [2];
  logic [CW-1:0]         countR [2];
  logic [CW-1:0]         emptyOff [2];
  logic [CW-1:0]         fullOff [2];
  logic [1:0]            space_q;
  logic [1:0]            spaceS1_q;
  logic [1:0]            high_q;
  logic [1:0]            highS1_q;
  logic [1:0]            low_q;
  logic [1:0]            lowS1_q;
  logic [1:0]            mailFlag_q;
  logic [35:0]           mailReg_q [2];
  logic [31:0]           ctrl_q;
  logic [`OFFSET_WIDTH-1:0] emptyOne_q;
  logic [`OFFSET_WIDTH-1:0] emptyTwo_q;
  logic [`OFFSET_WIDTH-1:0] fullOne_q;
  logic [`OFFSET_WIDTH-1:0] fullTwo_q;
  bus_size_type          busSize;
  logic [35:0]           mask;

  assign busSize = bus_size_type'(ctrl_q[`CTRL_SIZE_MSB:`CTRL_SIZE_LSB]);
  assign mask    = laneMask(busSize);

  assign aWriteSel = !portAPins.selectN && portAPins.direction && portAPins.enable && portAPins.clkEn;
  assign aReadSel  = !portAPins.selectN && !portAPins.direction && portAPins.enable && portAPins.clkEn;
  assign bWriteSel = !portBPins.selectN && !portBPins.direction && portBPins.enable && portBPins.clkEn;
  assign bReadSel  = !portBPins.selectN && portBPins.direction && portBPins.enable && portBPins.clkEn;

  assign wrClkEn = {portBPins.clkEn, portAPins.clkEn};
  assign rdClkEn = {portAPins.clkEn, portBPins.clkEn};

  // Writes blocked while no space is shown
  assign wrTake[0] = aWriteSel && !portAPins.mailboxSelect && space_q[0];
  assign wrTake[1] = bWriteSel && !portBPins.mailboxSelect && space_q[1];
  assign rdTake[0] = fifoOneRead && (count_q[0] != '0);
  assign rdTake[1] = fifoTwoRead && (count_q[1] != '0);

  // Mailbox selects the mail register instead of the FIFO
  assign mailWrite[0] = aWriteSel && portAPins.mailboxSelect && mailFlag_q[0];
  assign mailWrite[1] = bWriteSel && portBPins.mailboxSelect && mailFlag_q[1];
  assign mailRead[0]  = bReadSel && portBPins.mailboxSelect;
  assign mailRead[1]  = aReadSel && portAPins.mailboxSelect;

  assign emptyOff[0] = CW'(emptyOne_q);
  assign emptyOff[1] = CW'(emptyTwo_q);
  assign fullOff[0]  = CW'(fullOne_q);
  assign fullOff[1]  = CW'(fullTwo_q);

  // Own-edge events count now; far-side events only from registered count
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      countW[i] = count_q[i] + CW'(wrTake[i]);
      countR[i] = count_q[i] - CW'(rdTake[i]);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Fill level

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      count_q[0] <= '0;
      count_q[1] <= '0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        count_q[i] <= count_q[i] + CW'(wrTake[i]) - CW'(rdTake[i]);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Write-side flags: space and high fill

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      space_q   <= 2'h0;
      spaceS1_q <= 2'h0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (wrClkEn[i]) begin
          spaceS1_q[i] <= countW[i] < CW'(DEPTH);
          space_q[i]   <= (countW[i] < CW'(DEPTH)) && spaceS1_q[i];
        end
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      high_q   <= 2'h0;
      highS1_q <= 2'h0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (wrClkEn[i]) begin
          highS1_q[i] <= countW[i] + fullOff[i] + CW'(1) <= CW'(DEPTH);
          high_q[i]   <= (countW[i] + fullOff[i] + CW'(1) <= CW'(DEPTH)) && highS1_q[i];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read-side flag: low fill

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      low_q   <= 2'h0;
      lowS1_q <= 2'h0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (rdClkEn[i]) begin
          lowS1_q[i] <= countR[i] > emptyOff[i];
          low_q[i]   <= (countR[i] > emptyOff[i]) && lowS1_q[i];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Mailboxes

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      mailReg_q[0] <= 36'h0_0000_0000;
      mailReg_q[1] <= 36'h0_0000_0000;
    end else begin
      if (mailWrite[0]) begin
        mailReg_q[0] <= portAPins.data & mask;
      end
      if (mailWrite[1]) begin
        mailReg_q[1] <= portBPins.data & mask;
      end
    end
  end

  // New mail wins over a read in the same cycle
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      mailFlag_q <= 2'h3;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (mailWrite[i]) begin
          mailFlag_q[i] <= 1'b0;
        end else if (mailRead[i]) begin
          mailFlag_q[i] <= 1'b1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Data outputs

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      portAData   <= 36'h0_0000_0000;
      portADataOe <= 1'b0;
      portBData   <= 36'h0_0000_0000;
      portBDataOe <= 1'b0;
    end else begin
      portADataOe <= !portAPins.selectN && !portAPins.direction;
      portBDataOe <= !portBPins.selectN && portBPins.direction;
      portAData   <= portAPins.mailboxSelect ? mailReg_q[1] : fifoTwoOutData;
      portBData   <= portBPins.mailboxSelect ? mailReg_q[0] : fifoOneOutData;
    end
  end

  assign portASpaceFlag    = space_q[0];
  assign portBSpaceFlag    = space_q[1];
  assign portAHighFillFlag = high_q[0];
  assign portBHighFillFlag = high_q[1];
  assign portBLowFillFlag  = low_q[0];
  assign portALowFillFlag  = low_q[1];
  assign mailOneFlag       = mailFlag_q[0];
  assign mailTwoFlag       = mailFlag_q[1];

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write channel

  logic        awHeld_q;
  logic [7:0]  awAddr_q;
  logic        wHeld_q;
  logic [31:0] wData_q;
  logic [3:0]  wStrb_q;
  logic        awReady_q;
  logic        wReady_q;
  logic        bValid_q;
  logic [1:0]  bResp_q;
  logic        doWrite;
  logic        wrHit;

  assign doWrite = awHeld_q && wHeld_q && !bValid_q;
  assign wrHit   = awAddr_q inside {`REG_CTRL, `REG_EMPTY_ONE, `REG_EMPTY_TWO, `REG_FULL_ONE, `REG_FULL_TWO};

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      awHeld_q  <= 1'b0;
      awAddr_q  <= 8'h00;
      awReady_q <= 1'b0;
      wHeld_q   <= 1'b0;
      wData_q   <= 32'h0000_0000;
      wStrb_q   <= 4'h0;
      wReady_q  <= 1'b0;
    end else begin
      if (axiReq.awvalid && awReady_q) begin
        awHeld_q  <= 1'b1;
        awAddr_q  <= {axiReq.awaddr[7:2], 2'h0};
        awReady_q <= 1'b0;
      end else if (doWrite) begin
        awHeld_q  <= 1'b0;
      end else if (!awHeld_q && !bValid_q) begin
        awReady_q <= 1'b1;
      end
      if (axiReq.wvalid && wReady_q) begin
        wHeld_q  <= 1'b1;
        wData_q  <= axiReq.wdata;
        wStrb_q  <= axiReq.wstrb;
        wReady_q <= 1'b0;
      end else if (doWrite) begin
        wHeld_q  <= 1'b0;
      end else if (!wHeld_q && !bValid_q) begin
        wReady_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      bValid_q <= 1'b0;
      bResp_q  <= `RESP_OKAY;
    end else if (doWrite) begin
      bValid_q <= 1'b1;
      bResp_q  <= wrHit ? `RESP_OKAY : `RESP_SLVERR;
    end else if (bValid_q && axiReq.bready) begin
      bValid_q <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ctrl_q     <= `CTRL_RESET;
      emptyOne_q <= `OFFSET_RESET;
      emptyTwo_q <= `OFFSET_RESET;
      fullOne_q  <= `OFFSET_RESET;
      fullTwo_q  <= `OFFSET_RESET;
    end else if (doWrite) begin
      unique case (awAddr_q)
        `REG_CTRL:      ctrl_q     <= applyStrb(ctrl_q, wData_q, wStrb_q) & 32'h0000_0007;
        `REG_EMPTY_ONE: emptyOne_q <= 16'(applyStrb({16'h0000, emptyOne_q}, wData_q, wStrb_q));
        `REG_EMPTY_TWO: emptyTwo_q <= 16'(applyStrb({16'h0000, emptyTwo_q}, wData_q, wStrb_q));
        `REG_FULL_ONE:  fullOne_q  <= 16'(applyStrb({16'h0000, fullOne_q}, wData_q, wStrb_q));
        `REG_FULL_TWO:  fullTwo_q  <= 16'(applyStrb({16'h0000, fullTwo_q}, wData_q, wStrb_q));
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read channel

  logic        arReady_q;
  logic        rValid_q;
  logic [31:0] rData_q;
  logic [1:0]  rResp_q;
  logic [31:0] status;

  always_comb begin
    status = 32'h0000_0000;
    status[`STAT_SPACE_A]  = space_q[0];
    status[`STAT_SPACE_B]  = space_q[1];
    status[`STAT_HIGH_A]   = high_q[0];
    status[`STAT_HIGH_B]   = high_q[1];
    status[`STAT_LOW_A]    = low_q[1];
    status[`STAT_LOW_B]    = low_q[0];
    status[`STAT_MAIL_ONE] = mailFlag_q[0];
    status[`STAT_MAIL_TWO] = mailFlag_q[1];
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      arReady_q <= 1'b0;
      rValid_q  <= 1'b0;
      rData_q   <= 32'h0000_0000;
      rResp_q   <= `RESP_OKAY;
    end else if (axiReq.arvalid && arReady_q) begin
      arReady_q <= 1'b0;
      rValid_q  <= 1'b1;
      rResp_q   <= `RESP_OKAY;
      unique case ({axiReq.araddr[7:2], 2'h0})
        `REG_CTRL:      rData_q <= ctrl_q;
        `REG_EMPTY_ONE: rData_q <= {16'h0000, emptyOne_q};
        `REG_EMPTY_TWO: rData_q <= {16'h0000, emptyTwo_q};
        `REG_FULL_ONE:  rData_q <= {16'h0000, fullOne_q};
        `REG_FULL_TWO:  rData_q <= {16'h0000, fullTwo_q};
        `REG_STATUS:    rData_q <= status;
        `REG_LEVEL_ONE: rData_q <= 32'(count_q[0]);
        `REG_LEVEL_TWO: rData_q <= 32'(count_q[1]);
        default: begin
          rData_q <= 32'h0000_0000;
          rResp_q <= `RESP_SLVERR;
        end
      endcase
    end else if (rValid_q && axiReq.rready) begin
      rValid_q <= 1'b0;
    end else if (!rValid_q) begin
      arReady_q <= 1'b1;
    end
  end

  assign axiRsp = '{awready: awReady_q, wready: wReady_q, bvalid: bValid_q, bresp: bResp_q,
                    arready: arReady_q, rvalid: rValid_q, rdata: rData_q, rresp: rResp_q};

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  a_full_blocks_space: assert property (@(posedge sys_clk) disable iff (rst)
    wrTake[0] && !rdTake[0] && count_q[0] == CW'(DEPTH - 1) |=> !space_q[0])
    else $error("space flag stayed high at full");

  a_blocked_write_lost: assert property (@(posedge sys_clk) disable iff (rst)
    aWriteSel && !portAPins.mailboxSelect && !space_q[0] && !rdTake[0] |=> $stable(count_q[0]))
    else $error("write taken while space flag low");

  a_space_two_edges: assert property (@(posedge sys_clk) disable iff (rst)
    $rose(space_q[0]) |-> $past(spaceS1_q[0]) && $past(portAPins.clkEn))
    else $error("space flag rose without two write edges");

  a_low_fill_level: assert property (@(posedge sys_clk) disable iff (rst)
    low_q[0] |-> count_q[0] > emptyOff[0])
    else $error("low fill flag high at or below offset");

  a_high_fill_level: assert property (@(posedge sys_clk) disable iff (rst)
    high_q[1] |-> count_q[1] + fullOff[1] + CW'(1) <= CW'(DEPTH))
    else $error("high fill flag high above threshold");

  a_mail_write_flag: assert property (@(posedge sys_clk) disable iff (rst)
    mailWrite[0] |=> !mailFlag_q[0] && mailReg_q[0] == ($past(portAPins.data) & $past(mask)))
    else $error("mail write did not store or clear flag");

  a_mail_read_sets: assert property (@(posedge sys_clk) disable iff (rst)
    mailRead[1] && !mailWrite[1] |=> mailFlag_q[1])
    else $error("mail read did not set flag");

  a_mail_holds: assert property (@(posedge sys_clk) disable iff (rst)
    !mailWrite[1] |=> $stable(mailReg_q[1]))
    else $error("mail register changed without write");

  a_output_source: assert property (@(posedge sys_clk) disable iff (rst)
    portBPins.mailboxSelect ##1 portBDataOe |-> portBData == $past(mailReg_q[0]))
    else $error("port B output not from mail register");

endmodule // fifo_status_flags_and_mailbox

//--- pkg/fifo_flags_cfg.svh
// Register offsets, field positions and reset values of the flag and mailbox block
`ifndef FIFO_FLAGS_CFG_SVH
`define FIFO_FLAGS_CFG_SVH

`define REG_CTRL        8'h00
`define REG_EMPTY_ONE   8'h04
`define REG_EMPTY_TWO   8'h08
`define REG_FULL_ONE    8'h0C
`define REG_FULL_TWO    8'h10
`define REG_STATUS      8'h14
`define REG_LEVEL_ONE   8'h18
`define REG_LEVEL_TWO   8'h1C

`define CTRL_FALL_THROUGH_MODE_BIT   0
`define CTRL_SIZE_LSB   1
`define CTRL_SIZE_MSB   2
`define CTRL_RESET      32'h0000_0000

`define OFFSET_WIDTH    16
`define OFFSET_RESET    16'h0008

`define STAT_SPACE_A    0
`define STAT_SPACE_B    1
`define STAT_HIGH_A     2
`define STAT_HIGH_B     3
`define STAT_LOW_A      4
`define STAT_LOW_B      5
`define STAT_MAIL_ONE   6
`define STAT_MAIL_TWO   7

`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2

`define MASK_LONG       36'hF_FFFF_FFFF
`define MASK_WORD       36'h0_0003_FFFF
`define MASK_BYTE       36'h0_0000_01FF

`endif

//--- pkg/fifo_flags_pkg.sv
// Types shared by the flag and mailbox block
package fifo_flags_pkg;

  typedef enum logic [1:0] {
    BUS_LONG,
    BUS_WORD,
    BUS_BYTE,
    BUS_ILLEGAL
  } bus_size_type;

  typedef struct packed {
    logic        clkEn;
    logic        selectN;
    logic        direction;
    logic        enable;
    logic        mailboxSelect;
    logic [35:0] data;
  } port_pins_type;

  typedef struct packed {
    logic        awvalid;
    logic [31:0] awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [31:0] araddr;
    logic        rready;
  } axi_req_type;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } axi_rsp_type;

endpackage

//--- verification/port_edge_model.sv
// Far-side port clock model: one-cycle edge pulse every GAP system cycles
`timescale 1ns/10ps
module port_edge_model #(
  parameter int GAP = 2
) (
  input  wire logic sys_clk,
  input  wire logic rst,
  output      logic edgePulse
);
  logic [7:0] count_q;
  // Small GAP answers promptly, large GAP slowly
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      count_q   <= 8'h00;
      edgePulse <= 1'b0;
    end else begin
      count_q   <= (count_q == 8'(GAP - 1)) ? 8'h00 : count_q + 8'h01;
      edgePulse <= (count_q == 8'(GAP - 1));
    end
  end
endmodule // port_edge_model

//--- verification/testbench.sv
// Self-checking bench of the flag and mailbox block
`timescale 1ns/10ps
`include "fifo_flags_cfg.svh"
`define CHECK(g, e) begin samplesChecked++; if ((g) !== (e)) begin fails++; \
  $display("unexpected at %0t got %h exp %h", $time, g, e); end end
module testbench;
  import fifo_flags_pkg::*;
  localparam int DEPTH = 16;
  logic          sys_clk = 1'b0;
  logic          rst = 1'b1;
  axi_req_type   req = '0;
  axi_rsp_type   rsp;
  port_pins_type aCtl = '0;
  port_pins_type bCtl = '0;
  logic          aEdge, bEdge, spaceA, mailOne, mailTwo, aOe, bOe;
  logic          drainOne = 1'b0;
  logic [35:0]   outOne = 36'h0, outTwo = 36'h0, aData, bData, m;
  logic [33:0]   expQ[$];
  logic [33:0]   expNow;
  int            fails = 0, samplesChecked = 0, cycles = 0, i, s;

  ////////////////////////////////////////////////////////////////////////////
  port_edge_model #(.GAP(2)) edgeA (.sys_clk(sys_clk), .rst(rst), .edgePulse(aEdge));
  port_edge_model #(.GAP(3)) edgeB (.sys_clk(sys_clk), .rst(rst), .edgePulse(bEdge));
  fifo_status_flags_and_mailbox #(.DEPTH(DEPTH)) dut (.sys_clk(sys_clk), .rst(rst), .axiReq(req),
    .axiRsp(rsp), .portAPins({aEdge, aCtl[39:0]}), .portBPins({bEdge, bCtl[39:0]}),
    .fifoOneRead(bEdge & drainOne), .fifoTwoRead(1'b0), .fifoOneOutData(outOne), .fifoTwoOutData(outTwo),
    .portAData(aData), .portADataOe(aOe), .portBData(bData), .portBDataOe(bOe), .portASpaceFlag(spaceA),
    .portBSpaceFlag(), .portAHighFillFlag(), .portBHighFillFlag(), .portALowFillFlag(),
    .portBLowFillFlag(), .mailOneFlag(mailOne), .mailTwoFlag(mailTwo));

  initial begin
    forever #2 sys_clk = ~sys_clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read results checked against the oldest note; cycle ceiling
  always @(posedge sys_clk) begin
    cycles++;
    if (rsp.rvalid && req.rready && expQ.size() > 0) begin
      expNow = expQ.pop_front();
      `CHECK({rsp.rresp, rsp.rdata}, expNow)
    end
    if (cycles == 20000) begin
      fails++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", samplesChecked, fails);
    if (fails == 0 && samplesChecked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Bus and port cycles
  task automatic axiWrite(input logic [31:0] a, input logic [31:0] v);
    req.awvalid <= 1'b1;
    req.awaddr  <= a;
    req.wvalid  <= 1'b1;
    req.wdata   <= v;
    req.wstrb   <= 4'hF;
    req.bready  <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (rsp.awready) req.awvalid <= 1'b0;
      if (rsp.wready) req.wvalid <= 1'b0;
    end while (rsp.bvalid !== 1'b1);
    req.bready <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic axiRead(input logic [31:0] a, input logic [33:0] e);
    expQ.push_back(e);
    req.arvalid <= 1'b1;
    req.araddr  <= a;
    req.rready  <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (rsp.arready) req.arvalid <= 1'b0;
    end while (rsp.rvalid !== 1'b1);
    req.rready <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic portOp(input bit onA, input logic dir, input logic mbx, input logic [35:0] v);
    port_pins_type p;
    p = '{clkEn: 1'b0, selectN: 1'b0, direction: dir, enable: 1'b1, mailboxSelect: mbx, data: v};
    if (onA) aCtl <= p;
    else bCtl <= p;
    do @(posedge sys_clk); while ((onA ? aEdge : bEdge) !== 1'b1);
    p.enable = 1'b0;
    if (onA) aCtl <= p;
    else bCtl <= p;
    @(posedge sys_clk);
  endtask

  // Write on one port, refused rewrite, read on the other, FIFO view, reread
  task automatic mailTrip(input bit fromA, input logic [35:0] v, input logic [35:0] msk);
    portOp(fromA, fromA, 1'b1, v);
    `CHECK(fromA ? mailOne : mailTwo, 1'b0)
    portOp(fromA, fromA, 1'b1, ~v);
    portOp(!fromA, fromA, 1'b1, 36'h0);
    `CHECK(fromA ? bData : aData, v & msk)
    `CHECK(fromA ? bOe : aOe, 1'b1)
    `CHECK(fromA ? mailOne : mailTwo, 1'b1)
    portOp(!fromA, fromA, 1'b0, 36'h0);
    `CHECK(fromA ? bData : aData, fromA ? outOne : outTwo)
    portOp(!fromA, fromA, 1'b1, 36'h0);
    `CHECK(fromA ? bData : aData, v & msk)
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    s = $urandom(32'hF6ED);
    outOne = 36'({$urandom(), $urandom()});
    outTwo = 36'({$urandom(), $urandom()});
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (12) @(posedge sys_clk);
    axiRead(32'(`REG_CTRL), {`RESP_OKAY, `CTRL_RESET});
    axiRead(32'(`REG_FULL_TWO), {`RESP_OKAY, 16'h0, `OFFSET_RESET});
    axiRead(32'(`REG_STATUS), {`RESP_OKAY, 32'h0000_00CF});
    axiRead(32'h0000_0020, {`RESP_SLVERR, 32'h0});
    // Fill FIFO one; the last write is made while the flag is low
    for (i = 0; i < DEPTH + 1; i++) begin
      `CHECK(spaceA, 1'(i < DEPTH))
      portOp(1'b1, 1'b1, 1'b0, 36'(i));
    end
    repeat (12) @(posedge sys_clk);
    axiRead(32'(`REG_LEVEL_ONE), {`RESP_OKAY, 32'h0000_0010});
    axiRead(32'(`REG_STATUS), {`RESP_OKAY, 32'h0000_00EA});
    // One read frees a place; space returns on the second write-port edge
    drainOne <= 1'b1;
    do @(posedge sys_clk); while (bEdge !== 1'b1);
    drainOne <= 1'b0;
    do @(posedge sys_clk); while (aEdge !== 1'b1);
    @(posedge sys_clk);
    `CHECK(spaceA, 1'b0)
    do @(posedge sys_clk); while (aEdge !== 1'b1);
    @(posedge sys_clk);
    `CHECK(spaceA, 1'b1)
    // Mail in both directions for every bus size
    for (i = 0; i < 3; i++) begin
      axiWrite(32'(`REG_CTRL), 32'(i) << 1);
      axiRead(32'(`REG_CTRL), {`RESP_OKAY, 32'(i) << 1});
      m = (i == 0) ? `MASK_LONG : (i == 1) ? `MASK_WORD : `MASK_BYTE;
      for (s = 0; s < 2; s++) mailTrip(s == 0, 36'({$urandom(), $urandom()}), m);
    end
    print_verdict();
  end
endmodule // testbench
